// ==== include/raster_pkg.sv ====
// Shared constants and state types for the interlaced raster sync generator
package raster_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock
   localparam int CLK_PERIOD_NS = 25;

   ////////////////////////////////////////////////////////////////////////////
   // Line position counter (one step per trailing edge of the phase-3 pulse)
   localparam int          HPOS_W     = 6;
   localparam logic [5:0]  HPOS_ONE   = 6'h01;
   localparam logic [5:0]  HPOS_ZERO  = 6'h00;
   localparam logic [5:0]  HPOS_OPEN  = 6'h01;
   localparam logic [5:0]  HPOS_LOW   = 6'h05;
   localparam logic [5:0]  HPOS_CLOSE = 6'h0B;
   localparam logic [5:0]  HPOS_MID   = 6'h1B;
   localparam logic [5:0]  HPOS_HI    = 6'h2A;
   localparam logic [5:0]  HPOS_LAST  = 6'h2C;

   ////////////////////////////////////////////////////////////////////////////
   // Field line counter (one step per trailing edge of the twice-line tick)
   localparam int          FCNT_W        = 10;
   localparam logic [9:0]  FCNT_ONE      = 10'h001;
   localparam logic [9:0]  FCNT_ZERO     = 10'h000;
   localparam logic [9:0]  FIELD_LAST_60 = 10'h20C;
   localparam logic [9:0]  FIELD_LAST_50 = 10'h274;
   localparam logic [9:0]  REFRESH_A_60  = 10'h073;
   localparam logic [9:0]  REFRESH_B_60  = 10'h074;
   localparam logic [9:0]  REFRESH_A_50  = 10'h0AB;
   localparam logic [9:0]  REFRESH_B_50  = 10'h0AC;
   localparam logic [9:0]  VDRIVE_END    = 10'h011;
   localparam int          VEND_BIT_LO   = 0;
   localparam int          VEND_BIT_HI   = 4;

   ////////////////////////////////////////////////////////////////////////////
   // State records
   typedef struct packed
   {
      logic             ph3_q;
      logic [5:0]       cnt;
   } hpos_state_t;

   typedef struct packed
   {
      logic [9:0]       fcnt;
      logic             tick_q;
      logic             last_q;
      logic             c17_q;
      logic             open_q;
      logic             close_q;
      logic             mid_q;
      logic             hi_q;
      logic             field_a;
      logic             vdrive;
      logic             arm;
      logic             phase;
      logic             hdrive;
      logic             win;
      logic             hset;
      logic             flc;
      logic             srf;
   } sync_state_t;

   localparam hpos_state_t HPOS_RESET = '0;
   localparam sync_state_t SYNC_RESET = '0;

endpackage : raster_pkg

// ==== core/hpos_counter.sv ====
// Divide-by-45 line position counter with its position decodes
`timescale 1ns/100ps
module hpos_counter
(
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rstn,
   // Timing pulse in
   input  wire logic                        phase3_timing_pulse,
   // Position and decodes
   output logic [raster_pkg::HPOS_W-1:0]    hpos,
   output logic                             hsync_open_decode,
   output logic                             hpos_decode_low,
   output logic                             hsync_close_decode,
   output logic                             hpos_decode_mid,
   output logic                             hpos_decode_hi,
   output logic                             twice_line_tick
);
   import raster_pkg::*;

   hpos_state_t s_r;
   hpos_state_t s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ph3_q = phase3_timing_pulse;
      // Advance on the trailing edge, wrap after the last count
      if (s_r.ph3_q && !phase3_timing_pulse)
      begin
         s_nxt.cnt = (s_r.cnt == HPOS_LAST) ? HPOS_ZERO : s_r.cnt + HPOS_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         s_r <= HPOS_RESET;
      else
         s_r <= s_nxt;
   end

   assign hpos               = s_r.cnt;
   assign hsync_open_decode  = (s_r.cnt == HPOS_OPEN);
   assign hpos_decode_low    = (s_r.cnt == HPOS_LOW);
   assign hsync_close_decode = (s_r.cnt == HPOS_CLOSE);
   assign hpos_decode_mid    = (s_r.cnt == HPOS_MID);
   assign hpos_decode_hi     = (s_r.cnt == HPOS_HI);
   assign twice_line_tick    = (s_r.cnt == HPOS_LAST);

endmodule : hpos_counter

// ==== core/interlaced_raster_sync_generator.sv ====
// Interlaced raster sync generator: field, line and refresh timing
//
// What this block does
// - 50 Hz: field counter runs 0..628 then wraps; decodes 171, 172, 628.
// - 50 Hz: line decodes recur once per 20 ms field; count-17 decode rises on every count with bits 0 and 4 set.
// - 50 Hz: field A/B toggle follows the last-count decode; 20 ms gates.
// - Vertical drive from last-count rise to first following count-17 rise.
// - Vertical drive active low to monitor and remote copy, active high logic copy.
// - Line phase toggle divides the twice-line tick by two.
// - Phase high: monitor line pulse from count-42 rise to next count-27 fall.
// - Field A first line pulse precedes gate; field B one lags by half line.
// - First hsync open decode after field A rises forces line phase low.
// - Each field holds 262.5 (60 Hz) or 314.5 (50 Hz) line scans.
// - Remote copy and t-pulse hold copy of the monitor line pulse.
// - Set strobe and sync window only while line phase is low.
// - Sync window from open decode rise to close decode rise; to refresh.
// - Window ANDed with count-5 decode gives first line clear, both senses.
// - Start refresh on scan 58 (60 Hz) or 86 (50 Hz) of each field.
// - Refresh gate: line 115/171 with field A or 116/172 with field B passes window.
// - Line position counter steps on phase-3 trailing edge, wraps after 44.
// - 60 Hz: field counter steps on tick trailing edge, wraps after 524.
// - Field A/B gate toggles on each last-count decode rise.
`timescale 1ns/100ps
module interlaced_raster_sync_generator
(
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rstn,
   // Timing inputs
   input  wire logic                        phase3_timing_pulse,
   input  wire logic                        sel_50hz,
   // Field outputs
   output logic                             field_a,
   output logic                             field_b,
   output logic                             field_pulse,
   output logic                             monitor_field_pulse_n,
   output logic                             remote_field_pulse_n,
   // Line outputs
   output logic                             line_phase,
   output logic                             monitor_line_pulse_n,
   output logic                             remote_line_pulse_n,
   output logic                             tpulse_hold_n,
   output logic                             line_set_strobe,
   output logic                             hsync_window,
   output logic                             first_line_clear,
   output logic                             first_line_clear_n,
   output logic                             start_refresh,
   // Counter observation
   output logic [raster_pkg::HPOS_W-1:0]    line_pos,
   output logic [raster_pkg::FCNT_W-1:0]    field_pos
);
   import raster_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Line position counter

   logic hsync_open_decode;
   logic hpos_decode_low;
   logic hsync_close_decode;
   logic hpos_decode_mid;
   logic hpos_decode_hi;
   logic twice_line_tick;

   // Divide by 45
   hpos_counter u_hpos
   (
      .clk_sys             (clk_sys),
      .rstn                (rstn),
      .phase3_timing_pulse (phase3_timing_pulse),
      .hpos                (line_pos),
      .hsync_open_decode   (hsync_open_decode),
      .hpos_decode_low     (hpos_decode_low),
      .hsync_close_decode  (hsync_close_decode),
      .hpos_decode_mid     (hpos_decode_mid),
      .hpos_decode_hi      (hpos_decode_hi),
      .twice_line_tick     (twice_line_tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State

   sync_state_t s_r;
   sync_state_t s_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Field decodes

   logic [9:0] last_sel;
   logic [9:0] ref_a_sel;
   logic [9:0] ref_b_sel;
   logic       dec_last;
   logic       dec_17;
   logic       refresh_gate;

   // Static variant select
   assign last_sel  = sel_50hz ? FIELD_LAST_50 : FIELD_LAST_60;
   assign ref_a_sel = sel_50hz ? REFRESH_A_50 : REFRESH_A_60;
   assign ref_b_sel = sel_50hz ? REFRESH_B_50 : REFRESH_B_60;

   assign dec_last = (s_r.fcnt == last_sel);
   assign dec_17   = s_r.fcnt[VEND_BIT_LO] & s_r.fcnt[VEND_BIT_HI];

   // Line 115/171 of field A or 116/172 of field B
   assign refresh_gate = ((s_r.fcnt == ref_a_sel) & s_r.field_a)
                       | ((s_r.fcnt == ref_b_sel) & ~s_r.field_a);

   ////////////////////////////////////////////////////////////////////////////
   // Edge-detect enables

   logic tick_fall;
   logic last_rise;
   logic c17_rise;
   logic open_rise;
   logic close_rise;
   logic mid_fall;
   logic hi_rise;

   // Synchronous edges replace the ripple clocks
   assign tick_fall  = s_r.tick_q & ~twice_line_tick;
   assign last_rise  = dec_last & ~s_r.last_q;
   assign c17_rise   = dec_17 & ~s_r.c17_q;
   assign open_rise  = hsync_open_decode & ~s_r.open_q;
   assign close_rise = hsync_close_decode & ~s_r.close_q;
   assign mid_fall   = ~hpos_decode_mid & s_r.mid_q;
   assign hi_rise    = hpos_decode_hi & ~s_r.hi_q;

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.tick_q  = twice_line_tick;
      s_nxt.last_q  = dec_last;
      s_nxt.c17_q   = dec_17;
      s_nxt.open_q  = hsync_open_decode;
      s_nxt.close_q = hsync_close_decode;
      s_nxt.mid_q   = hpos_decode_mid;
      s_nxt.hi_q    = hpos_decode_hi;

      // Field counter: 525 or 629 half lines per field
      if (tick_fall)
      begin
         s_nxt.fcnt = dec_last ? FCNT_ZERO : s_r.fcnt + FCNT_ONE;
      end

      // Field gate toggle and vertical drive start
      if (last_rise)
      begin
         s_nxt.field_a = ~s_r.field_a;
         s_nxt.vdrive  = 1'b1;
         s_nxt.arm     = ~s_r.field_a;
      end
      else if (c17_rise)
      begin
         s_nxt.vdrive = 1'b0;
      end

      // Line phase divides the tick by two
      if (tick_fall)
      begin
         s_nxt.phase = ~s_r.phase;
      end
      // Realign at the first open decode of field A
      if (open_rise && s_r.arm)
      begin
         s_nxt.phase = 1'b0;
         s_nxt.arm   = 1'b0;
      end

      // Monitor line pulse, only started in the high phase
      if (hi_rise && s_r.phase)
      begin
         s_nxt.hdrive = 1'b1;
      end
      else if (mid_fall)
      begin
         s_nxt.hdrive = 1'b0;
      end

      // Sync window, only opened in the low phase
      if (open_rise && !s_r.phase)
      begin
         s_nxt.win = 1'b1;
      end
      else if (close_rise)
      begin
         s_nxt.win = 1'b0;
      end

      // One position step wide set strobe
      s_nxt.hset = hsync_open_decode & ~s_r.phase;

      // First line clear
      s_nxt.flc = s_r.win & hpos_decode_low;

      // Window passed only on the refresh line
      s_nxt.srf = s_r.win & refresh_gate;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         s_r <= SYNC_RESET;
      else
         s_r <= s_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign field_a               = s_r.field_a;
   assign field_b               = ~s_r.field_a;
   assign field_pulse           = s_r.vdrive;
   assign monitor_field_pulse_n = ~s_r.vdrive;
   assign remote_field_pulse_n  = ~s_r.vdrive;
   assign line_phase            = s_r.phase;
   assign monitor_line_pulse_n  = ~s_r.hdrive;
   assign remote_line_pulse_n   = ~s_r.hdrive;
   assign tpulse_hold_n         = ~s_r.hdrive;
   assign line_set_strobe       = s_r.hset;
   assign hsync_window          = s_r.win;
   assign first_line_clear      = s_r.flc;
   assign first_line_clear_n    = ~s_r.flc;
   assign start_refresh         = s_r.srf;
   assign field_pos             = s_r.fcnt;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys);
   endclocking

   default disable iff (!rstn);

   sequence s_field_end;
      tick_fall && dec_last;
   endsequence

   sequence s_field_start;
      last_rise;
   endsequence

   sequence s_vdrive_high;
      s_r.vdrive && !c17_rise;
   endsequence

   property p_field_wrap;
      s_field_end |=> (s_r.fcnt == FCNT_ZERO);
   endproperty
   a_field_wrap: assert property (p_field_wrap)
      else $error("field counter did not wrap after its last count");

   property p_field_step;
      tick_fall && !dec_last |=> (s_r.fcnt == $past(s_r.fcnt) + FCNT_ONE);
   endproperty
   a_field_step: assert property (p_field_step)
      else $error("field counter did not step on the tick");

   property p_field_toggle;
      s_field_start |=> (s_r.field_a != $past(s_r.field_a)) && s_r.vdrive;
   endproperty
   a_field_toggle: assert property (p_field_toggle)
      else $error("field gate or vertical drive missed the last count");

   property p_vdrive_end;
      $fell(s_r.vdrive) |-> ($past(s_r.fcnt) == VDRIVE_END);
   endproperty
   a_vdrive_end: assert property (p_vdrive_end)
      else $error("vertical drive ended away from count 17");

   property p_vdrive_hold;
      s_r.vdrive ##0 s_vdrive_high |=> s_r.vdrive;
   endproperty
   a_vdrive_hold: assert property (p_vdrive_hold)
      else $error("vertical drive dropped early");

   property p_phase_toggle;
      tick_fall && !(open_rise && s_r.arm) |=> (s_r.phase != $past(s_r.phase));
   endproperty
   a_phase_toggle: assert property (p_phase_toggle)
      else $error("line phase did not toggle on the tick");

   property p_phase_force;
      open_rise && s_r.arm |=> !s_r.phase && !s_r.arm;
   endproperty
   a_phase_force: assert property (p_phase_force)
      else $error("line phase not forced low at field A start");

   property p_hdrive_start;
      $rose(s_r.hdrive) |-> $past(s_r.phase) && $past(hi_rise);
   endproperty
   a_hdrive_start: assert property (p_hdrive_start)
      else $error("monitor line pulse started outside high phase");

   property p_window_phase;
      $rose(s_r.win) |-> !$past(s_r.phase) && $past(open_rise);
   endproperty
   a_window_phase: assert property (p_window_phase)
      else $error("sync window opened in high phase");

   property p_window_close;
      s_r.win && close_rise |=> !s_r.win;
   endproperty
   a_window_close: assert property (p_window_close)
      else $error("sync window not closed by close decode");

   property p_first_clear;
      s_r.win && hpos_decode_low |=> s_r.flc ##0 !first_line_clear_n;
   endproperty
   a_first_clear: assert property (p_first_clear)
      else $error("first line clear missing in window");

   property p_refresh;
      start_refresh |-> $past(s_r.win) && $past(refresh_gate);
   endproperty
   a_refresh: assert property (p_refresh)
      else $error("start refresh outside refresh line window");

   property p_field_only_on_last;
      $changed(s_r.field_a) |-> $past(last_rise);
   endproperty
   a_field_only_on_last: assert property (p_field_only_on_last)
      else $error("field gate changed away from the last count");

   property p_field_range;
      s_r.fcnt <= last_sel;
   endproperty
   a_field_range: assert property (p_field_range)
      else $error("field counter ran past its last count");

   property p_hpos_step;
      $changed(line_pos) |-> (line_pos <= HPOS_LAST)
         && ((line_pos == HPOS_ZERO) || (line_pos == $past(line_pos) + HPOS_ONE));
   endproperty
   a_hpos_step: assert property (p_hpos_step)
      else $error("line position skipped or ran past its last count");

   property p_set_phase;
      line_set_strobe |-> !$past(s_r.phase) && $past(hsync_open_decode);
   endproperty
   a_set_phase: assert property (p_set_phase)
      else $error("set strobe outside low phase open decode");

endmodule : interlaced_raster_sync_generator

// ==== verif/tpulse_source.sv ====
// Phase-3 timing pulse source standing in for the t-pulse generator
`timescale 1ns/100ps
module tpulse_source
(
   // Clock and reset
   input  wire logic   clk_sys,
   input  wire logic   rstn,
   // Pacing: 1 holds each level three clocks, 0 two clocks high and one low
   input  wire logic   slow,
   // Pulse out
   output logic        phase3_timing_pulse
);
   logic [2:0]         cnt_r;
   logic [2:0]         len_r;

   // Length is picked at each level change so no level is ever cut short
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_r               <= 3'h0;
         len_r               <= 3'h2;
         phase3_timing_pulse <= 1'h1;
      end
      else if (cnt_r == len_r - 3'h1)
      begin
         cnt_r               <= 3'h0;
         len_r               <= slow ? 3'h3 : (phase3_timing_pulse ? 3'h1 : 3'h2);
         phase3_timing_pulse <= !phase3_timing_pulse;
      end
      else
      begin
         cnt_r               <= cnt_r + 3'h1;
      end
   end
endmodule : tpulse_source

// ==== verif/testbench.sv ====
// Self-checking bench for the interlaced raster sync generator
`timescale 1ns/100ps
module testbench;
   import raster_pkg::*;
   typedef struct packed
   {
      logic       ph;
      logic [5:0] pos;
      logic       win;
      logic       set;
      logic       flc;
      logic       mpn;
   } row_t;
   localparam int   NROW = 14;
   localparam row_t ROWS [NROW] = '{
      '{1'h1, 6'h01, 1'h0, 1'h0, 1'h0, 1'h1}, '{1'h1, 6'h05, 1'h0, 1'h0, 1'h0, 1'h1},
      '{1'h1, 6'h29, 1'h0, 1'h0, 1'h0, 1'h1}, '{1'h1, 6'h2A, 1'h0, 1'h0, 1'h0, 1'h0},
      '{1'h1, 6'h2C, 1'h0, 1'h0, 1'h0, 1'h0}, '{1'h0, 6'h01, 1'h1, 1'h1, 1'h0, 1'h0},
      '{1'h0, 6'h02, 1'h1, 1'h0, 1'h0, 1'h0}, '{1'h0, 6'h05, 1'h1, 1'h0, 1'h1, 1'h0},
      '{1'h0, 6'h06, 1'h1, 1'h0, 1'h0, 1'h0}, '{1'h0, 6'h0A, 1'h1, 1'h0, 1'h0, 1'h0},
      '{1'h0, 6'h0B, 1'h0, 1'h0, 1'h0, 1'h0}, '{1'h0, 6'h1B, 1'h0, 1'h0, 1'h0, 1'h0},
      '{1'h0, 6'h1C, 1'h0, 1'h0, 1'h0, 1'h1}, '{1'h0, 6'h2C, 1'h0, 1'h0, 1'h0, 1'h1}};

   logic        clk_sys = 1'h0;
   logic        rstn = 1'h0;
   logic        sel_50hz = 1'h0;
   logic        slow = 1'h1;
   logic        phase3_timing_pulse;
   logic        field_a, field_b, field_pulse, monitor_field_pulse_n, remote_field_pulse_n;
   logic        line_phase, monitor_line_pulse_n, remote_line_pulse_n, tpulse_hold_n;
   logic        line_set_strobe, hsync_window, first_line_clear, first_line_clear_n;
   logic        start_refresh;
   logic [5:0]  line_pos;
   logic [9:0]  field_pos;
   logic        sr_q = 1'h0;
   logic        mp_q = 1'h1;
   int          refresh_rises = 0;
   int          line_falls = 0;
   int          miscompares = 0;
   int          samples_checked = 0;

   always #(CLK_PERIOD_NS / 2.0) clk_sys = !clk_sys;

   tpulse_source src_u (.clk_sys(clk_sys), .rstn(rstn), .slow(slow),
                        .phase3_timing_pulse(phase3_timing_pulse));

   interlaced_raster_sync_generator dut_u
   (
      .clk_sys(clk_sys), .rstn(rstn),
      .phase3_timing_pulse(phase3_timing_pulse), .sel_50hz(sel_50hz),
      .field_a(field_a), .field_b(field_b), .field_pulse(field_pulse),
      .monitor_field_pulse_n(monitor_field_pulse_n),
      .remote_field_pulse_n(remote_field_pulse_n),
      .line_phase(line_phase), .monitor_line_pulse_n(monitor_line_pulse_n),
      .remote_line_pulse_n(remote_line_pulse_n), .tpulse_hold_n(tpulse_hold_n),
      .line_set_strobe(line_set_strobe), .hsync_window(hsync_window),
      .first_line_clear(first_line_clear), .first_line_clear_n(first_line_clear_n),
      .start_refresh(start_refresh), .line_pos(line_pos), .field_pos(field_pos)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Event counters for the first field after reset
   always @(posedge clk_sys)
   begin
      sr_q <= start_refresh;
      mp_q <= monitor_line_pulse_n;
      if (start_refresh === 1'h1 && sr_q === 1'h0)
         refresh_rises++;
      if (monitor_line_pulse_n === 1'h0 && mp_q === 1'h1 && field_a === 1'h0)
         line_falls++;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Compare and wait tasks
   task automatic chk_bit(input string name, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask : chk_bit

   task automatic chk_vec(input string name, input logic [9:0] exp, input logic [9:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_vec

   task automatic chk_num(input string name, input int exp, input int got);
      samples_checked++;
      if (got != exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_num

   // Waits for a position, then waits two clocks to let the output latency of up to two clocks pass
   task automatic wait_at(input int fp, input int ph, input logic [5:0] pos, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      while (n < lim && !(line_pos === pos && (fp < 0 || field_pos === fp[9:0])
                          && (ph < 0 || line_phase === ph[0])));
      if (n >= lim)
      begin
         miscompares++;
         $display("MISMATCH position %0d/%0d expected reached seen timeout", fp, pos);
      end
      repeat (2) @(posedge clk_sys);
      #1;
   endtask : wait_at

   task automatic chk_reset;
      chk_vec("field_pos", 10'h000, field_pos);
      chk_vec("line_pos", 10'h000, {4'h0, line_pos});
      chk_bit("field_a", 1'h0, field_a);
      chk_bit("field_b", 1'h1, field_b);
      chk_bit("line_phase", 1'h0, line_phase);
      chk_bit("field_pulse", 1'h0, field_pulse);
      chk_bit("monitor_field_pulse_n", 1'h1, monitor_field_pulse_n);
      chk_bit("monitor_line_pulse_n", 1'h1, monitor_line_pulse_n);
      chk_bit("hsync_window", 1'h0, hsync_window);
      chk_bit("start_refresh", 1'h0, start_refresh);
   endtask : chk_reset

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      chk_reset();
      rstn <= 1'h1;
      foreach (ROWS[i])
      begin
         wait_at(-1, ROWS[i].ph, ROWS[i].pos, 2000);
         chk_bit("hsync_window", ROWS[i].win, hsync_window);
         chk_bit("line_set_strobe", ROWS[i].set, line_set_strobe);
         chk_bit("first_line_clear", ROWS[i].flc, first_line_clear);
         chk_bit("first_line_clear_n", !ROWS[i].flc, first_line_clear_n);
         chk_bit("monitor_line_pulse_n", ROWS[i].mpn, monitor_line_pulse_n);
         chk_bit("remote_line_pulse_n", ROWS[i].mpn, remote_line_pulse_n);
         chk_bit("tpulse_hold_n", ROWS[i].mpn, tpulse_hold_n);
      end
      slow <= 1'h0;
      wait_at(114, -1, 6'h01, 30000);
      chk_bit("hsync_window", 1'h1, hsync_window);
      chk_bit("start_refresh", 1'h0, start_refresh);
      wait_at(116, -1, 6'h01, 2000);
      chk_bit("start_refresh", 1'h1, start_refresh);
      wait_at(116, -1, 6'h0B, 2000);
      chk_bit("start_refresh", 1'h0, start_refresh);
      wait_at(523, -1, 6'h2A, 60000);
      chk_bit("monitor_line_pulse_n", 1'h0, monitor_line_pulse_n);
      chk_bit("field_a", 1'h0, field_a);
      wait_at(524, -1, 6'h01, 2000);
      chk_bit("field_a", 1'h1, field_a);
      chk_bit("field_b", 1'h0, field_b);
      chk_bit("field_pulse", 1'h1, field_pulse);
      chk_bit("monitor_field_pulse_n", 1'h0, monitor_field_pulse_n);
      chk_bit("remote_field_pulse_n", 1'h0, remote_field_pulse_n);
      chk_bit("line_phase", 1'h0, line_phase);
      chk_num("line pulses in field", 262, line_falls);
      chk_num("refresh starts in field", 1, refresh_rises);
      wait_at(0, -1, 6'h01, 2000);
      chk_bit("line_phase", 1'h1, line_phase);
      chk_vec("field_pos", 10'h000, field_pos);
      wait_at(16, -1, 6'h01, 5000);
      chk_bit("field_pulse", 1'h1, field_pulse);
      wait_at(17, -1, 6'h01, 2000);
      chk_bit("field_pulse", 1'h0, field_pulse);
      chk_bit("monitor_field_pulse_n", 1'h1, monitor_field_pulse_n);
      // Second reset in mid-run switches to the 50 Hz count set
      @(posedge clk_sys);
      rstn <= 1'h0;
      sel_50hz <= 1'h1;
      repeat (2) @(posedge clk_sys);
      chk_reset();
      rstn <= 1'h1;
      wait_at(116, -1, 6'h01, 30000);
      chk_bit("hsync_window", 1'h1, hsync_window);
      chk_bit("start_refresh", 1'h0, start_refresh);
      end_of_test();
   end

   initial
   begin
      repeat (98000) @(posedge clk_sys);
      miscompares++;
      $display("MISMATCH run length expected finished seen watchdog");
      end_of_test();
   end
endmodule : testbench
